// ### verilog/prg_ctrl.v
// Mode controller of the on-chip supply generator, with its APB register slave.
// Assumes oscillator status arrives asynchronously; CPU sleep events come from pclk logic.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "prg_map.vh"

module prg_ctrl #(
  parameter AUTO_CYC = `PRG_T_AUTO_US * `PRG_CLK_MHZ,
  parameter SETTLE_CYC = `PRG_T_SETTLE_US * `PRG_CLK_MHZ,
  parameter CNT_W = 17
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Oscillator status from the clock generator, asynchronous
  input wire internal_fast_osc_on,
  input wire external_fast_osc_on,
  input wire external_clock_input_on,
  input wire slow_osc_on,
  input wire slow_osc_clk,
  // CPU sleep events and sleep-stop configuration
  input wire sleep_enter,
  input wire wake_up,
  input wire slow_osc_sleep_stop,
  input wire fast_sleep_stop_all,
  // Regulator control
  output wire reg_economy,
  output wire pump_en,
  output wire pump_tick
);

  localparam [1:0] ST_NORM = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_SLPW = 2'h2;
  localparam [1:0] ST_ECO = 2'h3;

  // Three-stage synchronisers for the oscillator status lines.
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  reg [4:0] sync3_q;
  reg [4:0] filt_q;
  wire [4:0] raw_in;

  assign raw_in = {slow_osc_clk, slow_osc_on, external_clock_input_on,
                   external_fast_osc_on, internal_fast_osc_on};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      sync3_q <= 5'h00;
      filt_q <= 5'h00;
    end
    else
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // A change counts only once the second and third stages agree.
      filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
    end
  end

  wire fast_on;
  wire slow_on;
  wire slow_clk_lvl;

  assign fast_on = |filt_q[2:0];
  assign slow_on = filt_q[3];
  assign slow_clk_lvl = filt_q[4];

  // Register state.
  reg [15:0] protect_q;
  reg [2:0] mode_q;
  reg [1:0] div_q;
  reg done_flag_q;
  reg settling_q;
  reg sleeping_q;
  reg [1:0] st_q;
  reg [1:0] st_d;

  wire unlocked;
  wire wr_en;
  wire rd_setup;
  wire mode_wr;
  wire div_wr;
  wire flag_wr;
  wire addr_ok;

  assign unlocked = (protect_q == `PRG_KEY_OPEN);
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mode_wr = wr_en & unlocked & (paddr == `PRG_OFS_MODE);
  assign div_wr = wr_en & unlocked & (paddr == `PRG_OFS_PUMP);
  assign flag_wr = wr_en & (paddr == `PRG_OFS_FLAG);
  assign addr_ok = (paddr == `PRG_OFS_PROTECT) | (paddr == `PRG_OFS_MODE) |
                   (paddr == `PRG_OFS_PUMP) | (paddr == `PRG_OFS_FLAG) |
                   (paddr == `PRG_OFS_STATUS);

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  wire mode_auto;
  wire mode_eco;
  wire mode_super;
  wire [2:0] new_mode;
  wire leave_super;

  assign mode_auto = (mode_q == `PRG_MODE_AUTO);
  assign mode_eco = (mode_q == `PRG_MODE_ECONOMY);
  assign mode_super = (mode_q == `PRG_MODE_SUPER);
  assign new_mode = pwdata[2:0];
  assign leave_super = mode_wr & mode_super &
                       ((new_mode == `PRG_MODE_AUTO) | (new_mode == `PRG_MODE_ECONOMY));

  // Delay counters for the 1 ms automatic switch and the 10 ms settling time.
  wire auto_run;
  wire auto_done;
  wire settle_done;

  assign auto_run = mode_auto & ~settling_q & ((st_q == ST_WAIT) | (st_q == ST_SLPW));

  prg_delay #(
    .CYCLES(AUTO_CYC),
    .CNT_W(CNT_W)
  ) u_auto_delay (
    .pclk(pclk),
    .presetn(presetn),
    .run(auto_run),
    .done(auto_done)
  );

  prg_delay #(
    .CYCLES(SETTLE_CYC),
    .CNT_W(CNT_W)
  ) u_settle_delay (
    .pclk(pclk),
    .presetn(presetn),
    .run(settling_q),
    .done(settle_done)
  );

  // Wake-up choice: economy only if the slow oscillator alone runs.
  wire wake_eco;

  assign wake_eco = slow_on & ~fast_on;

  // Automatic switching state machine.
  always @*
  begin
    st_d = st_q;
    case (st_q)
      ST_NORM:
      begin
        if (sleep_enter)
        begin
          if (fast_sleep_stop_all & slow_osc_sleep_stop)
            st_d = ST_ECO;
          else if (fast_sleep_stop_all)
            st_d = ST_SLPW;
          else
            st_d = ST_NORM;
        end
        else if (wake_up)
          st_d = wake_eco ? ST_ECO : ST_NORM;
        else if (!sleeping_q && !fast_on)
          st_d = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (sleep_enter)
        begin
          if (fast_sleep_stop_all & slow_osc_sleep_stop)
            st_d = ST_ECO;
          else if (fast_sleep_stop_all)
            st_d = ST_SLPW;
          else
            st_d = ST_NORM;
        end
        else if (fast_on)
          st_d = ST_NORM;
        else if (auto_done)
          st_d = ST_ECO;
      end
      ST_SLPW:
      begin
        if (wake_up)
          st_d = wake_eco ? ST_ECO : ST_NORM;
        else if (auto_done)
          st_d = ST_ECO;
      end
      ST_ECO:
      begin
        if (wake_up)
          st_d = wake_eco ? ST_ECO : ST_NORM;
        else if (!sleeping_q && fast_on)
          st_d = ST_NORM;
      end
      default:
        st_d = ST_NORM;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= ST_NORM;
    else if (leave_super)
      st_q <= ST_ECO;
    else if (mode_wr && (new_mode == `PRG_MODE_AUTO) && !mode_auto)
      st_q <= ST_NORM;
    else if (!mode_auto || settling_q)
      st_q <= st_q;
    else
      st_q <= st_d;
  end

  // Flag set by a timed switch; a set in the clearing cycle wins.
  wire flag_set;

  assign flag_set = settle_done | (auto_done & ~settling_q);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      protect_q <= `PRG_KEY_RST;
      mode_q <= `PRG_MODE_RST;
      div_q <= `PRG_DIV_RST;
      done_flag_q <= 1'b0;
      settling_q <= 1'b0;
      sleeping_q <= 1'b0;
    end
    else
    begin
      if (wr_en && (paddr == `PRG_OFS_PROTECT))
        protect_q <= pwdata[15:0];
      if (mode_wr)
        mode_q <= new_mode;
      if (div_wr)
        div_q <= pwdata[1:0];
      if (flag_set)
        done_flag_q <= 1'b1;
      else if (flag_wr && pwdata[0])
        done_flag_q <= 1'b0;
      if (leave_super)
        settling_q <= 1'b1;
      else if (settle_done || mode_wr)
        settling_q <= 1'b0;
      if (sleep_enter)
        sleeping_q <= 1'b1;
      else if (wake_up)
        sleeping_q <= 1'b0;
    end
  end

  // Automatic economy drops in the same cycle a fast source is seen starting, except during sleep.
  wire auto_eco;

  assign auto_eco = mode_auto & (st_q == ST_ECO) & ~(fast_on & ~sleeping_q);
  assign reg_economy = mode_eco | auto_eco;
  assign pump_en = mode_super;

  // Charge pump clock: slow oscillator edges divided by 1, 2, 4 or 8.
  reg slow_prev_q;
  reg [2:0] div_cnt_q;
  reg pump_tick_q;
  wire slow_rise;
  wire [2:0] div_last;

  assign slow_rise = slow_clk_lvl & ~slow_prev_q;
  assign div_last = (3'h1 << div_q) - 3'h1;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_prev_q <= 1'b0;
      div_cnt_q <= 3'h0;
      pump_tick_q <= 1'b0;
    end
    else
    begin
      slow_prev_q <= slow_clk_lvl;
      pump_tick_q <= 1'b0;
      if (!mode_super)
        div_cnt_q <= 3'h0;
      else if (slow_rise)
      begin
        // The pump runs on slow oscillator edges only, also in sleep.
        if (div_cnt_q >= div_last)
        begin
          div_cnt_q <= 3'h0;
          pump_tick_q <= 1'b1;
        end
        else
          div_cnt_q <= div_cnt_q + 3'h1;
      end
    end
  end

  assign pump_tick = pump_tick_q;

  // Read data is captured in the setup cycle and shown in the access cycle.
  reg [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h00000000;
    case (paddr)
      `PRG_OFS_PROTECT:
        rd_mux[0] = ~unlocked;
      `PRG_OFS_MODE:
        rd_mux[2:0] = mode_q;
      `PRG_OFS_PUMP:
        rd_mux[1:0] = div_q;
      `PRG_OFS_FLAG:
        rd_mux[0] = done_flag_q;
      `PRG_OFS_STATUS:
      begin
        rd_mux[`PRG_ST_ECO] = reg_economy;
        rd_mux[`PRG_ST_PUMP] = pump_en;
        rd_mux[`PRG_ST_SLEEP] = sleeping_q;
        rd_mux[`PRG_ST_SETTLE] = settling_q;
        rd_mux[`PRG_ST_FAST] = fast_on;
        rd_mux[`PRG_ST_SLOW] = slow_on;
      end
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_setup)
      prdata <= rd_mux;
  end

endmodule // prg_ctrl

// ### shared/prg_map.vh
// Register map, field codes and timing figures of the supply generator mode controller.
// Included by the design files; holds definitions only.
`ifndef PRG_MAP_VH
`define PRG_MAP_VH

// Register byte offsets.
`define PRG_OFS_PROTECT 8'h00
`define PRG_OFS_MODE 8'h04
`define PRG_OFS_PUMP 8'h08
`define PRG_OFS_FLAG 8'h0C
`define PRG_OFS_STATUS 8'h10

// System protection key and its width.
`define PRG_KEY_W 16
`define PRG_KEY_OPEN 16'h0096
`define PRG_KEY_RST 16'h0000

// Power mode field codes and reset value.
`define PRG_MODE_W 3
`define PRG_MODE_AUTO 3'h0
`define PRG_MODE_NORMAL 3'h2
`define PRG_MODE_ECONOMY 3'h3
`define PRG_MODE_SUPER 3'h5
`define PRG_MODE_RST 3'h0

// Pump clock divider field and reset value.
`define PRG_DIV_W 2
`define PRG_DIV_RST 2'h0

// Status register bit positions.
`define PRG_ST_ECO 0
`define PRG_ST_PUMP 1
`define PRG_ST_SLEEP 2
`define PRG_ST_SETTLE 3
`define PRG_ST_FAST 4
`define PRG_ST_SLOW 5

// Timing: clock rate in MHz and settling times in microseconds.
`define PRG_CLK_MHZ 10
`define PRG_T_AUTO_US 1000
`define PRG_T_SETTLE_US 10000

`endif

// ### verilog/prg_delay.v
// Run-time delay counter: counts while run is high and holds done high from the end of the delay until run drops.
// Assumes run is a level from logic on the same clock.
`timescale 1ns/1ps

module prg_delay #(
  parameter CYCLES = 10000,
  parameter CNT_W = 17
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire run,
  output wire done
);

  localparam [31:0] LAST_FULL = CYCLES - 1;
  localparam [CNT_W-1:0] LAST = LAST_FULL[CNT_W-1:0];

  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;

  assign done = run & (cnt_q == LAST);

  always @*
  begin
    if (!run)
      cnt_d = {CNT_W{1'b0}};
    else if (cnt_q == LAST)
      cnt_d = cnt_q;
    else
      cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= {CNT_W{1'b0}};
    else
      cnt_q <= cnt_d;
  end

endmodule // prg_delay

// ### verification/prg_ctrl_props.sv
// Port-level checker for the supply generator mode controller.
// Assumes the bench never runs a fast source in economy or super economy.
`timescale 1ns/1ps
`include "prg_map.vh"

module prg_ctrl_props (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Status and regulator control
  input wire internal_fast_osc_on,
  input wire external_fast_osc_on,
  input wire external_clock_input_on,
  input wire reg_economy,
  input wire pump_en,
  input wire pump_tick
);
  reg armed_q;
  reg [2:0] fast_cnt_q;
  wire wr = psel && penable && pwrite;
  wire fast = internal_fast_osc_on || external_fast_osc_on || external_clock_input_on;
  wire mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08 || paddr == 8'h0C
    || paddr == 8'h10;
  wire mode_wr = wr && paddr == `PRG_OFS_MODE && !armed_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_q <= 1'b1;
    else if (wr && paddr == `PRG_OFS_PROTECT)
      armed_q <= pwdata[15:0] != `PRG_KEY_OPEN;
  end

  // Counts how long a fast source has run, saturating at seven.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fast_cnt_q <= 3'h0;
    else if (!fast)
      fast_cnt_q <= 3'h0;
    else if (fast_cnt_q != 3'h7)
      fast_cnt_q <= fast_cnt_q + 3'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_high: assert property (pready) else $error("pready low");
  a_slverr_decode: assert property (pslverr == (psel && penable && !mapped))
    else $error("pslverr wrong");
  a_reset_quiet: assert property (disable iff (1'b0) !presetn |->
    (prdata == 32'h0 && !reg_economy && !pump_en && !pump_tick)) else $error("reset outputs");
  a_prdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("prdata moved");
  a_tick_single: assert property (pump_tick |=> !pump_tick) else $error("tick long");
  a_fast_no_eco: assert property (fast_cnt_q == 3'h7 |-> !reg_economy)
    else $error("economy with fast");
  a_lock_ignore: assert property (wr && paddr == `PRG_OFS_MODE && armed_q |=> $stable(pump_en))
    else $error("locked write");
  a_mode_super: assert property (mode_wr && pwdata[2:0] == `PRG_MODE_SUPER |=> pump_en)
    else $error("no pump");
  a_mode_normal: assert property (mode_wr && pwdata[2:0] == `PRG_MODE_NORMAL
    |=> !pump_en && !reg_economy) else $error("not normal");
  a_mode_economy: assert property (mode_wr && pwdata[2:0] == `PRG_MODE_ECONOMY
    |=> reg_economy && !pump_en) else $error("not economy");
endmodule // prg_ctrl_props

bind prg_ctrl prg_ctrl_props prg_ctrl_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .internal_fast_osc_on(internal_fast_osc_on),
  .external_fast_osc_on(external_fast_osc_on), .external_clock_input_on(external_clock_input_on),
  .reg_economy(reg_economy), .pump_en(pump_en), .pump_tick(pump_tick));

// ### verification/power_regulator_mode_control_tb.sv
// Self-checking bench for the mode controller, driving APB and oscillator status.
// Assumes the design reads its map header and shortened delay parameters.
`timescale 1ns/1ps
`include "prg_map.vh"

module power_regulator_mode_control_tb;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic r;} prg_row_t;
  localparam int AUTO = 20;
  localparam int SETTLE = 50;
  logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic slow_clk = 0, sleep_go = 0, wake_go = 0, slow_stop = 0, fast_stop = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [2:0] fast_on = 3'h1;
  logic [1:0] div_q = 0;
  wire [31:0] prdata;
  wire pready, pslverr, reg_economy, pump_en, pump_tick;
  int n_errors = 0, check_count = 0, n, k, t;
  prg_row_t rows [15];

  prg_ctrl #(.AUTO_CYC(AUTO), .SETTLE_CYC(SETTLE), .CNT_W(17)) prg_ctrl_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_fast_osc_on(fast_on[0]), .external_fast_osc_on(fast_on[1]),
    .external_clock_input_on(fast_on[2]), .slow_osc_on(1'b1), .slow_osc_clk(slow_clk),
    .sleep_enter(sleep_go), .wake_up(wake_go), .slow_osc_sleep_stop(slow_stop),
    .fast_sleep_stop_all(fast_stop), .reg_economy(reg_economy), .pump_en(pump_en),
    .pump_tick(pump_tick));

  always #50 pclk = ~pclk;
  // Slow crystal clock with a period of eight system cycles.
  always @(posedge pclk)
  begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3)
      slow_clk <= ~slow_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1)
    begin
      n_errors++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic unlock_wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1, `PRG_OFS_PROTECT, 32'h0096);
    xfer(1, a, d);
    xfer(1, `PRG_OFS_PROTECT, 32'h0);
  endtask

  task automatic wait_eco(input logic v, input int lim);
    n = 0;
    #1;
    while (reg_economy !== v && n < lim)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (reg_economy !== v)
    begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  task automatic pulse(input logic s);
    @(posedge pclk);
    sleep_go <= s;
    wake_go <= !s;
    @(posedge pclk);
    sleep_go <= 0;
    wake_go <= 0;
  endtask

  initial
  begin
    // Reset is asserted as an event at time zero so that every flip-flop starts defined.
    presetn <= 0;
    rows = '{'{0, 8'h00, 0, 1, 0}, '{0, 8'h04, 0, 0, 0}, '{0, 8'h0C, 0, 0, 0},
      '{1, 8'h00, 32'h96, 0, 0}, '{0, 8'h00, 0, 0, 0}, '{1, 8'h08, 3, 0, 0},
      '{0, 8'h08, 0, 3, 0}, '{1, 8'h04, 2, 0, 0}, '{0, 8'h10, 0, 32'h30, 0},
      '{0, 8'h14, 0, 0, 1}, '{1, 8'h00, 32'h1234, 0, 0}, '{1, 8'h04, 5, 0, 0},
      '{0, 8'h04, 0, 2, 0}, '{1, 8'h08, 1, 0, 0}, '{0, 8'h08, 0, 3, 0}};
    repeat (3) @(posedge pclk);
    #1 chk({prdata[0], reg_economy, pump_en, pump_tick, pslverr}, 0);
    @(posedge pclk);
    presetn <= 1;
    for (k = 0; k < 15; k++)
    begin
      xfer(rows[k].w, rows[k].a, rows[k].d);
      if (!rows[k].w) chk(rd, rows[k].e);
      chk(32'(er), 32'(rows[k].r));
    end
    $display("register table done");
    unlock_wr(`PRG_OFS_MODE, `PRG_MODE_AUTO);
    for (k = 0; k < 3; k++)
    begin
      fast_on <= 0;
      wait_eco(1, 200);
      chk(32'(n >= AUTO && n <= AUTO + 8), 1);
      xfer(0, `PRG_OFS_FLAG, 0);
      chk(rd, 1);
      xfer(1, `PRG_OFS_FLAG, 1);
      fast_on <= 3'h1 << k;
      wait_eco(0, 8);
    end
    $display("automatic switching done");
    for (k = 0; k < 2; k++)
    begin
      fast_stop <= 1;
      slow_stop <= !k;
      fast_on <= 0;
      pulse(1);
      wait_eco(1, 200);
      chk(32'(k ? n >= AUTO - 4 && n <= AUTO + 8 : n <= 3), 1);
      repeat (AUTO + 8) @(posedge pclk);
      xfer(0, `PRG_OFS_FLAG, 0);
      chk(rd, k);
      xfer(1, `PRG_OFS_FLAG, 1);
      pulse(0);
      #1 chk(32'(reg_economy), 1);
      fast_on <= 1;
      wait_eco(0, 8);
    end
    fast_stop <= 0;
    pulse(1);
    repeat (AUTO + 10) @(posedge pclk);
    #1 chk(32'(reg_economy), 0);
    pulse(0);
    repeat (3) @(posedge pclk);
    #1 chk(32'(reg_economy), 0);
    $display("sleep cases done");
    fast_on <= 0;
    wait_eco(1, 200);
    unlock_wr(`PRG_OFS_PUMP, 0);
    unlock_wr(`PRG_OFS_MODE, `PRG_MODE_SUPER);
    for (k = 0; k < 4; k++)
    begin
      unlock_wr(`PRG_OFS_PUMP, k);
      repeat (16) @(posedge pclk);
      n = 0;
      repeat (320)
      begin
        @(posedge pclk);
        #1 n += 32'(pump_tick === 1'b1);
      end
      chk(32'(n >= 320 / (8 << k) - 1 && n <= 320 / (8 << k) + 1), 1);
    end
    slow_stop <= 0;
    fast_stop <= 1;
    pulse(1);
    pulse(0);
    chk(32'(pump_en), 1);
    xfer(1, `PRG_OFS_FLAG, 1);
    xfer(1, `PRG_OFS_PROTECT, 32'h0096);
    xfer(1, `PRG_OFS_MODE, `PRG_MODE_ECONOMY);
    t = $time;
    xfer(1, `PRG_OFS_PROTECT, 0);
    // The read data register still shows the last flag read, so start from zero.
    rd = 0;
    for (k = 0; k < 100 && rd[0] !== 1'b1; k++)
      xfer(0, `PRG_OFS_FLAG, 0);
    chk(32'(rd[0]), 1);
    t = ($time - t) / 100;
    chk(32'(t >= SETTLE && t <= SETTLE + 6), 1);
    chk({reg_economy, pump_en}, 2);
    $display("super economy done");
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    #1 chk({prdata[0], reg_economy, pump_en, pump_tick}, 0);
    @(posedge pclk);
    presetn <= 1;
    xfer(0, `PRG_OFS_MODE, 0);
    chk(rd, `PRG_MODE_RST);
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule // power_regulator_mode_control_tb
